// *** rtl/pec_consts.svh ***
// Offsets, field positions, reset values and counts of the performance event counters
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

`define PEC_NUM_CH 4
`define PEC_CNT_W 32
`define PEC_SEL_W 6
`define PEC_NUM_SRC 38

// Register byte offsets
`define PEC_OFF_CTRL 8'h00
`define PEC_OFF_SEL 8'h04
`define PEC_OFF_STATUS 8'h08
`define PEC_OFF_COUNT0 8'h10
`define PEC_OFF_COUNT3 8'h1c

// Control register fields
`define PEC_CTRL_MODE_LSB 0
`define PEC_CTRL_MODE_MSB 1
`define PEC_CTRL_INIT_BIT 2

// Source select field pitch in the select register
`define PEC_SEL_PITCH 8

// Status register fields
`define PEC_ST_OVF_LSB 0
`define PEC_ST_ACTIVE_BIT 4
`define PEC_ST_ERR_BIT 5
`define PEC_ST_INACC_BIT 6

// Reset values
`define PEC_CTRL_RST 32'h0000_0000
`define PEC_SEL_RST 32'h0000_0000

// Branch events advance the counter by this step
`define PEC_BRANCH_STEP 32'h0000_0002

// AXI responses
`define PEC_RESP_OKAY 2'b00
`define PEC_RESP_SLVERR 2'b10

`endif

// *** rtl/pec_pkg.sv ***
// Types shared by the performance event counter modules
package pec_pkg;

  typedef enum logic [1:0] {
    PEC_MODE_NORMAL = 2'h0,
    PEC_MODE_1TO2 = 2'h1,
    PEC_MODE_2TO1 = 2'h2,
    PEC_MODE_RSVD = 2'h3
  } pec_mode_t;

  typedef enum logic [3:0] {
    PEC_ST_IDLE = 4'h1,
    PEC_ST_WAIT = 4'h2,
    PEC_ST_COUNT = 4'h4,
    PEC_ST_DONE = 4'h8
  } pec_state_t;

  // Source codes; the event input vector is indexed by the same code
  typedef enum logic [5:0] {
    PEC_SRC_DISABLED = 6'h00, PEC_SRC_ELAPSED = 6'h01, PEC_SRC_CYCLES = 6'h02,
    PEC_SRC_BRANCH = 6'h03, PEC_SRC_INSTR = 6'h04, PEC_SRC_DSP = 6'h05,
    PEC_SRC_ID_CONFLICT = 6'h06, PEC_SRC_OTHER_CONFLICT = 6'h07, PEC_SRC_EXC_IRQ = 6'h08,
    PEC_SRC_DTLB_MISS = 6'h09, PEC_SRC_ITLB_MISS = 6'h0a, PEC_SRC_IRQ = 6'h0b,
    PEC_SRC_BLOCKED = 6'h0c, PEC_SRC_PRIV = 6'h0d, PEC_SRC_IC_MISS = 6'h0e,
    PEC_SRC_DC_MISS = 6'h0f, PEC_SRC_IF_STALL = 6'h10, PEC_SRC_DA_STALL = 6'h11,
    PEC_SRC_IC_STALL = 6'h12, PEC_SRC_DC_STALL = 6'h13, PEC_SRC_C_STALL = 6'h14,
    PEC_SRC_XY_STALL = 6'h15, PEC_SRC_U_STALL = 6'h16, PEC_SRC_ACC_STALL = 6'h17,
    PEC_SRC_OTHER_ACC = 6'h18, PEC_SRC_NC_CYC = 6'h19, PEC_SRC_NC_I_CYC = 6'h1a,
    PEC_SRC_NC_D_CYC = 6'h1b, PEC_SRC_C_CYC = 6'h1c, PEC_SRC_C_I_CYC = 6'h1d,
    PEC_SRC_C_D_CYC = 6'h1e, PEC_SRC_OTHER_ACC_N = 6'h1f, PEC_SRC_NC_N = 6'h20,
    PEC_SRC_NC_I_N = 6'h21, PEC_SRC_NC_D_N = 6'h22, PEC_SRC_C_N = 6'h23,
    PEC_SRC_C_I_N = 6'h24, PEC_SRC_C_D_N = 6'h25
  } pec_src_t;

endpackage

// *** rtl/pec_range_ctrl.sv ***
// Measurement window controller: start and end of counting per run mode
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_range_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire pec_pkg::pec_mode_t mode,
  input wire logic all_disabled,
  input wire logic init,
  // Execution and comparator events
  input wire logic run_start,
  input wire logic break_halt,
  input wire logic cmp1_match,
  input wire logic cmp2_match,
  // Status
  output logic active,
  output logic cfg_err
);
  import pec_pkg::*;

  pec_state_t state_q;
  logic range_mode;
  logic start_hit;
  logic end_hit;

  assign range_mode = (mode == PEC_MODE_1TO2) || (mode == PEC_MODE_2TO1);
  assign start_hit = (mode == PEC_MODE_1TO2) ? cmp1_match : cmp2_match;
  assign end_hit = (mode == PEC_MODE_1TO2) ? cmp2_match : cmp1_match;
  assign active = (state_q == PEC_ST_COUNT);

  // A range with nothing to count is refused at run start and flagged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_err <= 1'b0;
    end else if (run_start && range_mode && all_disabled) begin
      cfg_err <= 1'b1;
    end else if (init) begin
      cfg_err <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= PEC_ST_IDLE;
    end else if (init) begin
      state_q <= PEC_ST_IDLE;
    end else begin
      case (state_q)
        PEC_ST_IDLE, PEC_ST_DONE: begin
          if (run_start && mode == PEC_MODE_NORMAL) begin
            state_q <= PEC_ST_COUNT;
          end else if (run_start && range_mode && !all_disabled) begin
            state_q <= PEC_ST_WAIT;
          end
        end
        PEC_ST_WAIT: begin
          if (break_halt) begin
            state_q <= PEC_ST_DONE;
          end else if (start_hit) begin
            state_q <= PEC_ST_COUNT;
          end
        end
        PEC_ST_COUNT: begin
          if (break_halt) begin
            state_q <= PEC_ST_DONE;
          end else if (range_mode && end_hit) begin
            state_q <= PEC_ST_DONE;
          end
        end
        default: begin
          state_q <= PEC_ST_IDLE;
        end
      endcase
    end
  end

endmodule // pec_range_ctrl

// *** rtl/pec_channel.sv ***
// One 32-bit event counting channel with source select and sticky overflow
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_channel #(
  parameter int CNT_W = `PEC_CNT_W,
  parameter int NSRC = `PEC_NUM_SRC,
  parameter logic [`PEC_NUM_SRC-1:0] FEAT_MASK = '1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire pec_pkg::pec_src_t sel,
  input wire logic active,
  input wire logic cpu_sleep,
  input wire logic init,
  // Events
  input wire logic [NSRC-1:0] events,
  // Result
  output logic [CNT_W-1:0] count,
  output logic ovf
);
  import pec_pkg::*;

  logic [CNT_W-1:0] step;
  logic [CNT_W:0] sum;

  // Step applied this cycle for the selected source
  function automatic logic [CNT_W-1:0] step_of(input pec_src_t s, input logic [NSRC-1:0] ev);
    logic [CNT_W-1:0] r;
    r = '0;
    case (s)
      PEC_SRC_DISABLED: r = '0;
      PEC_SRC_ELAPSED: r = CNT_W'(1);
      PEC_SRC_BRANCH: r = ev[PEC_SRC_BRANCH] ? CNT_W'(`PEC_BRANCH_STEP) : '0;
      default: r = (ev[s] && FEAT_MASK[s]) ? CNT_W'(1) : '0;
    endcase
    return r;
  endfunction

  // Sleep stands for the stopped CPU clock: nothing advances while it is high
  assign step = (active && !cpu_sleep) ? step_of(sel, events) : '0;
  assign sum = {1'b0, count} + {1'b0, step};

  // Saturate on wrap so a wrapped value is never mistaken for a small one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (init) begin
      count <= '0;
    end else if (sum[CNT_W]) begin
      count <= '1;
    end else begin
      count <= sum[CNT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf <= 1'b0;
    end else if (sum[CNT_W]) begin
      ovf <= 1'b1;
    end else if (init) begin
      ovf <= 1'b0;
    end
  end

endmodule // pec_channel

// *** rtl/pec_top.sv ***
// Four-channel performance event counter unit with AXI4-Lite register access
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_top #(
  parameter int NUM_CH = `PEC_NUM_CH,
  parameter int CNT_W = `PEC_CNT_W,
  parameter bit HAS_DSP = 1'b1,
  parameter bit HAS_MMU = 1'b1,
  parameter bit HAS_XY = 1'b1,
  parameter bit HAS_U = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU execution and break logic, same clock
  input wire logic run_start,
  input wire logic break_halt,
  input wire logic cmp1_match,
  input wire logic cmp2_match,
  input wire logic cpu_sleep,
  input wire logic trace_nonrealtime,
  input wire logic [`PEC_NUM_SRC-1:0] cpu_events,
  // To break logic
  output logic cmp_break_suppress,
  output logic overflow_any
);
  import pec_pkg::*;

  // ---------------------------------------------------------------------------
  // Feature gating
  // ---------------------------------------------------------------------------
  localparam logic [`PEC_NUM_SRC-1:0] FEAT_MASK =
    ~(((`PEC_NUM_SRC)'(!HAS_DSP)) << PEC_SRC_DSP
    | ((`PEC_NUM_SRC)'(!HAS_MMU)) << PEC_SRC_DTLB_MISS
    | ((`PEC_NUM_SRC)'(!HAS_MMU)) << PEC_SRC_ITLB_MISS
    | ((`PEC_NUM_SRC)'(!HAS_XY)) << PEC_SRC_XY_STALL
    | ((`PEC_NUM_SRC)'(!HAS_U)) << PEC_SRC_U_STALL);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  pec_mode_t mode_q;
  logic [31:0] sel_q;
  logic init_q;
  logic inacc_q;
  logic active;
  logic cfg_err;
  logic all_disabled;
  logic [NUM_CH-1:0] ovf;
  logic [CNT_W-1:0] count [NUM_CH];

  logic [7:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic wr_fire;

  function automatic pec_src_t sel_of(input logic [31:0] s, input int ch);
    return pec_src_t'(s[ch*`PEC_SEL_PITCH +: `PEC_SEL_W]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    all_disabled = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      if (sel_of(sel_q, c) != PEC_SRC_DISABLED) begin
        all_disabled = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ---------------------------------------------------------------------------
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end else begin
      // Stay closed while a response is pending so no second write slips in
      s_axi_awready <= !aw_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PEC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awaddr_q[7:2] == (`PEC_OFF_CTRL >> 2) ||
                      awaddr_q[7:2] == (`PEC_OFF_SEL >> 2)) ? `PEC_RESP_OKAY
                                                             : `PEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= pec_mode_t'(2'(`PEC_CTRL_RST));
    end else if (wr_fire && awaddr_q[7:2] == (`PEC_OFF_CTRL >> 2) && wstrb_q[0]) begin
      mode_q <= pec_mode_t'(wdata_q[`PEC_CTRL_MODE_MSB:`PEC_CTRL_MODE_LSB]);
    end
  end

  // Init is a one-cycle command; the bit always reads back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_q <= 1'b0;
    end else begin
      init_q <= wr_fire && awaddr_q[7:2] == (`PEC_OFF_CTRL >> 2) && wstrb_q[0] &&
                wdata_q[`PEC_CTRL_INIT_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= `PEC_SEL_RST;
    end else if (wr_fire && awaddr_q[7:2] == (`PEC_OFF_SEL >> 2)) begin
      sel_q <= merge(sel_q, wdata_q, wstrb_q);
    end
  end

  // Non-realtime trace disturbs stalls and cycles, so results are marked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inacc_q <= 1'b0;
    end else if (active && trace_nonrealtime) begin
      inacc_q <= 1'b1;
    end else if (init_q) begin
      inacc_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Measurement window and channels
  // ---------------------------------------------------------------------------
  pec_range_ctrl u_range (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(mode_q),
    .all_disabled(all_disabled),
    .init(init_q),
    .run_start(run_start),
    .break_halt(break_halt),
    .cmp1_match(cmp1_match),
    .cmp2_match(cmp2_match),
    .active(active),
    .cfg_err(cfg_err)
  );

  // Area events arrive classified by address region, not by cache result,
  // so TLB-uncached accesses already fall in the cacheable class
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    pec_channel #(
      .CNT_W(CNT_W),
      .NSRC(`PEC_NUM_SRC),
      .FEAT_MASK(FEAT_MASK)
    ) u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(sel_of(sel_q, c)),
      .active(active),
      .cpu_sleep(cpu_sleep),
      .init(init_q),
      .events(cpu_events),
      .count(count[c]),
      .ovf(ovf[c])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_break_suppress <= 1'b0;
    end else begin
      cmp_break_suppress <= (mode_q == PEC_MODE_1TO2) || (mode_q == PEC_MODE_2TO1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_any <= 1'b0;
    end else begin
      overflow_any <= |ovf;
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PEC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PEC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr[7:2] == (`PEC_OFF_CTRL >> 2)) begin
        s_axi_rdata[`PEC_CTRL_MODE_MSB:`PEC_CTRL_MODE_LSB] <= mode_q;
      end else if (s_axi_araddr[7:2] == (`PEC_OFF_SEL >> 2)) begin
        s_axi_rdata <= sel_q;
      end else if (s_axi_araddr[7:2] == (`PEC_OFF_STATUS >> 2)) begin
        s_axi_rdata[`PEC_ST_OVF_LSB +: `PEC_NUM_CH] <= ovf;
        s_axi_rdata[`PEC_ST_ACTIVE_BIT] <= active;
        s_axi_rdata[`PEC_ST_ERR_BIT] <= cfg_err;
        s_axi_rdata[`PEC_ST_INACC_BIT] <= inacc_q;
      end else if (s_axi_araddr >= `PEC_OFF_COUNT0 && s_axi_araddr <= `PEC_OFF_COUNT3) begin
        s_axi_rdata <= count[s_axi_araddr[3:2]];
      end else begin
        s_axi_rresp <= `PEC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pec_top

// *** test/pec_top_sva.sv ***
// Port checker for the performance counter unit
`timescale 1ns/1ns
`include "pec_consts.svh"
module pec_top_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status
  input wire logic overflow_any
);
  logic [7:0] wa_q;
  logic [7:0] ra_q;
  logic [2:0] sw_q;
  wire logic wmap = wa_q inside {`PEC_OFF_CTRL, `PEC_OFF_SEL};
  wire logic rmap = ra_q inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c};
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  // Cycles since the last write data; init lands a few cycles after it
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready)) sw_q <= 3'h0;
    else if (sw_q != 3'h7) sw_q <= sw_q + 3'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while response pending");
  a_wr_map: assert property (s_axi_bvalid
    |-> s_axi_bresp == (wmap ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR))
    else $error("wrong write response");
  a_rd_map: assert property (s_axi_rvalid |-> rmap ? s_axi_rresp == `PEC_RESP_OKAY
    : s_axi_rresp == `PEC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("wrong read response");
  a_ovf_sticky: assert property (overflow_any && sw_q == 3'h7 |=> overflow_any)
    else $error("overflow flag lost");
  c_wr_err: cover property (s_axi_bvalid && s_axi_bresp == `PEC_RESP_SLVERR);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == `PEC_RESP_SLVERR);
  c_rd_cnt: cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
endmodule // pec_top_sva

// *** test/pec_break_model.sv ***
// Break comparator and execution control model facing the counter unit
`timescale 1ns/1ns
module pec_break_model (
  // Clock, request code from the bench and break suppress from the unit
  input wire logic aclk,
  input wire logic [2:0] go,
  input wire logic cmp_break_suppress,
  // Pulses to the unit
  output logic run_start,
  output logic cmp1_match,
  output logic cmp2_match,
  output logic break_halt
);
  always_ff @(posedge aclk) begin
    run_start <= go == 3'd1;
    cmp1_match <= go == 3'd2;
    cmp2_match <= go == 3'd3;
    // A match halts the CPU unless it only bounds a range
    break_halt <= go == 3'd4 || ((go == 3'd2 || go == 3'd3) && !cmp_break_suppress);
  end
endmodule // pec_break_model

// *** test/tb.sv ***
// Self-checking bench for the performance counter unit
`timescale 1ns/1ns
`include "pec_consts.svh"
module tb;
  import pec_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic run_start, break_halt, cmp1_match, cmp2_match, cpu_sleep, trace_nonrealtime;
  logic [`PEC_NUM_SRC-1:0] cpu_events;
  logic cmp_break_suppress, overflow_any;
  logic [2:0] go;
  int error_cnt, n_checks, md;
  int cnt[4];
  int sel_m[4];
  bit act_m, wait_m;
  pec_top pec_top_i (.*);
  pec_break_model pec_break_model_i (.*);
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  // Events and sleep change every cycle, counted or not
  always @(posedge aclk) begin
    cpu_events <= `PEC_NUM_SRC'({$urandom, $urandom});
    cpu_sleep <= $urandom_range(4) == 0;
  end
  function automatic int inc(int c, logic [`PEC_NUM_SRC-1:0] e);
    if (c < 2) return c;
    if (c == PEC_SRC_BRANCH) return e[c] ? 2 : 0;
    return e[c] ? 1 : 0;
  endfunction
  // Reference window and counters
  always @(posedge aclk) begin
    if (act_m && !cpu_sleep) foreach (cnt[i]) cnt[i] += inc(sel_m[i], cpu_events);
    if (act_m && (break_halt || (md == 1 && cmp2_match) || (md == 2 && cmp1_match))) act_m = 0;
    if (wait_m && ((md == 1 && cmp1_match) || (md == 2 && cmp2_match))) begin
      act_m = 1;
      wait_m = 0;
    end
    if (run_start && !act_m && !wait_m) begin
      act_m = md == 0;
      // A range with every channel disabled is refused; mode 3 never runs
      wait_m = (md == 1 || md == 2) && (sel_m[0] | sel_m[1] | sel_m[2] | sel_m[3]) != 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (t >= 50) error_cnt++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (t >= 50) error_cnt++;
  endtask
  task automatic pulse(input logic [2:0] c);
    go <= c;
    @(posedge aclk);
    go <= 3'd0;
    repeat (3) @(posedge aclk);
  endtask
  // Initialise and pick the mode in one write, then pick the four sources
  task automatic setup(input int m, input int s[4]);
    logic [1:0] r;
    wr(`PEC_OFF_CTRL, 32'(m) | 32'h4, r);
    repeat (2) @(posedge aclk);
    act_m = 0;
    wait_m = 0;
    md = m;
    foreach (cnt[i]) cnt[i] = 0;
    sel_m = s;
    wr(`PEC_OFF_SEL, {8'(s[3]), 8'(s[2]), 8'(s[1]), 8'(s[0])}, r);
  endtask
  task automatic chk_run();
    logic [31:0] d;
    logic [1:0] r;
    rd(`PEC_OFF_STATUS, d, r);
    chk(32'(d[4]), 32'(act_m));
    chk(32'(d[3:0]), 32'h0);
    chk(32'(overflow_any), 32'h0);
    foreach (cnt[i]) begin
      rd(8'h10 + 8'(4 * i), d, r);
      chk(d, cnt[i]);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int s[4];
    void'($urandom(32'h777651ce));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go, trace_nonrealtime} <= '0;
    s_axi_wstrb <= 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (s[i]) s[i] = 4 * i;
    foreach (s[i]) begin
      rd(8'(s[i]), d, r);
      chk(d, 32'h0);
    end
    rd(8'h0c, d, r);
    chk(32'(r), 32'(`PEC_RESP_SLVERR));
    wr(`PEC_OFF_STATUS, 32'hffff_ffff, r);
    chk(32'(r), 32'(`PEC_RESP_SLVERR));
    $display("test reset_map done");
    for (int b = 0; b < `PEC_NUM_SRC; b += 4) begin
      foreach (s[i]) s[i] = b + i < `PEC_NUM_SRC ? b + i : 0;
      setup(0, s);
      chk(32'(cmp_break_suppress), 32'h0);
      pulse(3'd1);
      repeat ($urandom_range(60, 20)) @(posedge aclk);
      pulse(3'd2);
      chk_run();
    end
    $display("test sources done");
    for (int m = 1; m < 3; m++) begin
      foreach (s[i]) s[i] = $urandom_range(`PEC_NUM_SRC - 1, 1);
      setup(m, s);
      chk(32'(cmp_break_suppress), 32'h1);
      pulse(3'd1);
      trace_nonrealtime <= 1'b1;
      pulse(m == 1 ? 3'd2 : 3'd3);
      repeat ($urandom_range(60, 20)) @(posedge aclk);
      trace_nonrealtime <= 1'b0;
      pulse(m == 1 ? 3'd3 : 3'd2);
      chk_run();
      repeat (20) @(posedge aclk);
      chk_run();
      rd(`PEC_OFF_STATUS, d, r);
      chk(32'(d[6]), 32'h1);
    end
    $display("test ranges done");
    s = '{0, 0, 0, 0};
    setup(1, s);
    pulse(3'd1);
    rd(`PEC_OFF_STATUS, d, r);
    chk(32'(d[5:4]), 32'h2);
    s = '{1, 2, 3, 4};
    setup(3, s);
    chk(32'(cmp_break_suppress), 32'h0);
    pulse(3'd1);
    chk_run();
    setup(0, s);
    rd(`PEC_OFF_STATUS, d, r);
    chk(32'(d[6:0]), 32'h0);
    chk_run();
    $display("test init done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    summarize();
  end
endmodule // tb
bind pec_top pec_top_sva pec_top_sva_i (.*);
